//--- pkg/tsio_pkg.sv
package tsio_pkg;

	localparam int NPORT = 5;
	localparam int NPIN = 32;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int SH_CNT_W = 6;
	localparam int PORT_IDX_W = 3;

	// Port widths, narrowest first; port k covers pins 0 .. width-1
	localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};

	// Configuration word fields (OP_CFG data)
	localparam int CFG_EN = 0;
	localparam int CFG_DIR = 1;
	localparam int CFG_OD = 2;
	localparam int CFG_CLK = 3;
	localparam int CFG_STRB = 4;
	localparam int CFG_W = 5;

	localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
	localparam logic [SH_CNT_W-1:0] SH_CNT_RST = 6'h00;

	// Clock block select values; block 0 is the reference clock
	localparam logic CLKBLK_REF = 1'b0;
	localparam logic CLKBLK_EXT = 1'b1;

	// The 1-bit port whose pin may act as external clock source
	localparam int CLKSRC_PORT = 0;
	localparam int CLKSRC_PIN = 0;

	typedef enum logic [2:0] {
		OP_CFG,
		OP_OUT,
		OP_IN,
		OP_TIME,
		OP_COND,
		OP_CNT,
		OP_TS,
		OP_PEEK
	} tsio_op_t;

endpackage : tsio_pkg

//--- rtl/tsio_pin_cell.sv
`timescale 1ns/1ps
module tsio_pin_cell (
	// Ownership requests, index 0 is the narrowest port
	input logic [tsio_pkg::NPORT-1:0] claim,
	input logic linkEn,
	// Per-port drive state for this pin
	input logic [tsio_pkg::NPORT-1:0] outBit,
	input logic [tsio_pkg::NPORT-1:0] dirOut,
	input logic [tsio_pkg::NPORT-1:0] openDrain,
	// Pin
	output logic pinOut,
	output logic pinOe
);
	import tsio_pkg::*;

	logic [NPORT-1:0] live;
	logic [NPORT-1:0] owner;
	logic drive;
	logic val;
	logic odSel;

	// Link takes the pin from every port
	assign live = linkEn ? '0 : claim;
	// Lowest set bit wins: narrower port beats wider ones
	assign owner = live & NPORT'(~live + NPORT'(1));
	assign drive = |(owner & dirOut);
	assign val = |(owner & outBit);
	assign odSel = |(owner & openDrain);

	// Open drain only ever drives a zero
	assign pinOut = odSel ? 1'b0 : val;
	assign pinOe = drive & (odSel ? ~val : 1'b1);

endmodule : tsio_pin_cell

//--- rtl/tsio_port_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Five ports: widths 1, 4, 8, 16, 32
// - One direction bit per port, all pins
// - Drive pins, sample them, optional condition wait
// - Each core command answered next cycle
// - Open drain: zero pulls low, one floats
// - Open drain chosen once per whole port
// - Shift register plus transfer register buffer data
// - 16-bit counter times transfers
// - Counter readable at any time
// - Transfer delayed until counter equals target
// - Counter captured as timestamp on transfer
// - Enabled link disables ports on its pins
// - Narrower enabled port owns shared pin
// - Unclaimed pins stay with wider port
// - Ports always transfer full width
// - Pin events go straight to scheduler
// - Reset selects clock block zero
// - Accept input strobe, emit output strobe
// - 1-bit port pin can clock ports
module tsio_port_top (
	// Clock and reset
	input logic clk_sys,
	input logic rstn,
	// Core command port
	input logic cmdValid,
	output logic cmdReady,
	input logic [tsio_pkg::PORT_IDX_W-1:0] cmdPort,
	input tsio_pkg::tsio_op_t cmdOp,
	input logic [tsio_pkg::DATA_W-1:0] cmdData,
	output logic rspValid,
	output logic [tsio_pkg::DATA_W-1:0] rspData,
	// Scheduler events
	output logic [tsio_pkg::NPORT-1:0] portEvent,
	// Strobes
	input logic [tsio_pkg::NPORT-1:0] readyIn,
	output logic [tsio_pkg::NPORT-1:0] readyOut,
	// Link pin sharing
	input logic [tsio_pkg::NPIN-1:0] linkEn,
	// Pins
	input logic [tsio_pkg::NPIN-1:0] pinIn,
	output logic [tsio_pkg::NPIN-1:0] pinOut,
	output logic [tsio_pkg::NPIN-1:0] pinOe
);
	import tsio_pkg::*;

	// Per-port state gathered for selection and pin muxing
	logic [CFG_W-1:0] cfgA [NPORT];
	logic [CNT_W-1:0] cntA [NPORT];
	logic [CNT_W-1:0] tsA [NPORT];
	logic [DATA_W-1:0] rxA [NPORT];
	logic [DATA_W-1:0] outValA [NPORT];
	logic [DATA_W-1:0] peekA [NPORT];
	logic [NPORT-1:0] txFullA;
	logic [NPORT-1:0] rxFullA;
	logic [NPORT-1:0] enA;
	logic [NPORT-1:0] dirA;
	logic [NPORT-1:0] odA;

	logic clkPrev_reg;
	logic extEdge;
	logic portOk;
	logic [PORT_IDX_W-1:0] pIdx;
	logic cmdFire;
	logic [DATA_W-1:0] rspNext;
	logic rspValid_reg;
	logic [DATA_W-1:0] rspData_reg;

	// External clock from the 1-bit port pin, only when that port samples it
	assign extEdge = pinIn[CLKSRC_PIN] & ~clkPrev_reg & enA[CLKSRC_PORT]
		& ~dirA[CLKSRC_PORT];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clkPrev_reg <= 1'b0;
		end else begin
			clkPrev_reg <= pinIn[CLKSRC_PIN];
		end
	end

	// Command decode
	assign portOk = cmdPort < PORT_IDX_W'(NPORT);
	assign pIdx = portOk ? cmdPort : '0;
	// Blocking data moves stall through ready rather than being dropped
	assign cmdReady = !portOk ? 1'b1 :
		(cmdOp == OP_OUT) ? (!txFullA[pIdx] && dirA[pIdx]) :
		(cmdOp == OP_IN) ? rxFullA[pIdx] : 1'b1;
	assign cmdFire = cmdValid & cmdReady;

	for (genvar g = 0; g < NPORT; g++) begin : gPort
		localparam int W = PORT_W[g];
		localparam int BEATS = DATA_W / W;
		localparam logic [SH_CNT_W-1:0] LAST = SH_CNT_W'(BEATS - 1);
		localparam logic [DATA_W-1:0] WMASK = DATA_W'((64'h1 << W) - 64'h1);

		logic [CFG_W-1:0] cfg_reg;
		logic [CNT_W-1:0] cnt_reg;
		logic [CNT_W-1:0] ts_reg;
		logic [CNT_W-1:0] timeVal_reg;
		logic timeArm_reg;
		logic [DATA_W-1:0] condVal_reg;
		logic condArm_reg;
		logic [DATA_W-1:0] tx_reg;
		logic txFull_reg;
		logic [DATA_W-1:0] sh_reg;
		logic [SH_CNT_W-1:0] shCnt_reg;
		logic [DATA_W-1:0] rx_reg;
		logic rxFull_reg;
		logic [DATA_W-1:0] outVal_reg;
		logic evt_reg;
		logic rdyOut_reg;

		logic sel;
		logic wrCfg;
		logic wrOut;
		logic rdIn;
		logic wrTime;
		logic wrCond;
		logic tick;
		logic timeOk;
		logic condOk;
		logic strbOk;
		logic [DATA_W-1:0] inShift;
		logic inBeat;
		logic inDone;
		logic outLoad;
		logic outShift;

		assign sel = cmdFire && portOk && (cmdPort == PORT_IDX_W'(g));
		assign wrCfg = sel && (cmdOp == OP_CFG);
		assign wrOut = sel && (cmdOp == OP_OUT);
		assign rdIn = sel && (cmdOp == OP_IN);
		assign wrTime = sel && (cmdOp == OP_TIME);
		assign wrCond = sel && (cmdOp == OP_COND);

		// Port clock: reference every cycle, or edge of the 1-bit port pin
		assign tick = cfg_reg[CFG_EN] &&
			((cfg_reg[CFG_CLK] == CLKBLK_EXT) ? extEdge : 1'b1);
		assign timeOk = !timeArm_reg || (cnt_reg == timeVal_reg);
		// Condition looks at all pins of the port, owned or not
		assign condOk = !condArm_reg || ((pinIn & WMASK) == condVal_reg);
		assign strbOk = !cfg_reg[CFG_STRB] || readyIn[g];
		// Least significant beat first; full word after BEATS samples
		assign inShift = DATA_W'({pinIn, sh_reg} >> W);

		// A word only starts when the receive register has room
		assign inBeat = tick && !cfg_reg[CFG_DIR] && strbOk &&
			((shCnt_reg != '0) || (timeOk && condOk && !rxFull_reg));
		assign inDone = inBeat && (shCnt_reg == LAST);
		assign outLoad = tick && cfg_reg[CFG_DIR] && (shCnt_reg == '0) &&
			txFull_reg && timeOk;
		assign outShift = tick && cfg_reg[CFG_DIR] && (shCnt_reg != '0);

		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				cfg_reg <= CFG_RST;
				cnt_reg <= CNT_RST;
				ts_reg <= CNT_RST;
			end else begin
				if (wrCfg) begin
					cfg_reg <= cmdData[CFG_W-1:0];
				end
				if (tick) begin
					cnt_reg <= CNT_W'(cnt_reg + CNT_W'(1));
				end
				if (inDone || outLoad) begin
					ts_reg <= cnt_reg;
				end
			end
		end

		// Arming wins over the disarm of a transfer in the same cycle
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				timeArm_reg <= 1'b0;
				timeVal_reg <= CNT_RST;
				condArm_reg <= 1'b0;
				condVal_reg <= DATA_RST;
			end else begin
				if (wrTime) begin
					timeArm_reg <= 1'b1;
					timeVal_reg <= cmdData[CNT_W-1:0];
				end else if (inDone || outLoad || wrCfg) begin
					timeArm_reg <= 1'b0;
				end
				if (wrCond) begin
					condArm_reg <= 1'b1;
					condVal_reg <= cmdData & WMASK;
				end else if (inDone || wrCfg) begin
					condArm_reg <= 1'b0;
				end
			end
		end

		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				tx_reg <= DATA_RST;
				txFull_reg <= 1'b0;
				rx_reg <= DATA_RST;
				rxFull_reg <= 1'b0;
			end else begin
				if (wrOut) begin
					tx_reg <= cmdData;
				end
				txFull_reg <= wrOut | (txFull_reg & ~outLoad & ~wrCfg);
				if (inDone) begin
					rx_reg <= inShift;
				end
				// New word set wins over a read clearing the flag
				rxFull_reg <= inDone | (rxFull_reg & ~rdIn & ~wrCfg);
			end
		end

		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				sh_reg <= DATA_RST;
				shCnt_reg <= SH_CNT_RST;
				outVal_reg <= DATA_RST;
			end else if (wrCfg) begin
				shCnt_reg <= SH_CNT_RST;
			end else if (inBeat) begin
				sh_reg <= inShift;
				shCnt_reg <= inDone ? SH_CNT_RST : SH_CNT_W'(shCnt_reg + SH_CNT_W'(1));
			end else if (outLoad) begin
				outVal_reg <= tx_reg;
				sh_reg <= tx_reg >> W;
				shCnt_reg <= LAST;
			end else if (outShift) begin
				outVal_reg <= sh_reg;
				sh_reg <= sh_reg >> W;
				shCnt_reg <= SH_CNT_W'(shCnt_reg - SH_CNT_W'(1));
			end
		end

		// Event and strobe pulses line up with the registered pin data
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				evt_reg <= 1'b0;
				rdyOut_reg <= 1'b0;
			end else begin
				evt_reg <= inDone | outLoad;
				rdyOut_reg <= outLoad | outShift;
			end
		end

		assign cfgA[g] = cfg_reg;
		assign cntA[g] = cnt_reg;
		assign tsA[g] = ts_reg;
		assign rxA[g] = rx_reg;
		assign outValA[g] = outVal_reg;
		assign peekA[g] = pinIn & WMASK;
		assign txFullA[g] = txFull_reg;
		assign rxFullA[g] = rxFull_reg;
		assign enA[g] = cfg_reg[CFG_EN];
		assign dirA[g] = cfg_reg[CFG_DIR];
		assign odA[g] = cfg_reg[CFG_OD];
		assign portEvent[g] = evt_reg;
		assign readyOut[g] = rdyOut_reg;
	end

	// Answer to the command one cycle after it is taken
	assign rspNext = !portOk ? DATA_RST :
		(cmdOp == OP_CFG) ? DATA_W'(cfgA[pIdx]) :
		(cmdOp == OP_IN) ? rxA[pIdx] :
		(cmdOp == OP_CNT) ? DATA_W'(cntA[pIdx]) :
		(cmdOp == OP_TS) ? DATA_W'(tsA[pIdx]) :
		(cmdOp == OP_PEEK) ? peekA[pIdx] : DATA_RST;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rspValid_reg <= 1'b0;
			rspData_reg <= DATA_RST;
		end else begin
			rspValid_reg <= cmdFire;
			if (cmdFire) begin
				rspData_reg <= rspNext;
			end
		end
	end

	assign rspValid = rspValid_reg;
	assign rspData = rspData_reg;

	// Pin ownership, one cell per pin
	for (genvar p = 0; p < NPIN; p++) begin : gPin
		logic [NPORT-1:0] claim;
		logic [NPORT-1:0] outBit;

		for (genvar k = 0; k < NPORT; k++) begin : gClaim
			// A port claims only pins within its width; others stay with wider ports
			assign claim[k] = enA[k] && (p < PORT_W[k]);
			assign outBit[k] = outValA[k][p];
		end

		tsio_pin_cell uCell (
			.claim(claim),
			.linkEn(linkEn[p]),
			.outBit(outBit),
			.dirOut(dirA),
			.openDrain(odA),
			.pinOut(pinOut[p]),
			.pinOe(pinOe[p])
		);
	end

endmodule : tsio_port_top

//--- tb/tsio_port_sva.sv
`timescale 1ns/1ps
module tsio_port_sva (
	// Clock and reset
	input logic clk_sys,
	input logic rstn,
	// Commands
	input logic cmdValid,
	input logic cmdReady,
	input logic [tsio_pkg::PORT_IDX_W-1:0] cmdPort,
	input tsio_pkg::tsio_op_t cmdOp,
	input logic [tsio_pkg::DATA_W-1:0] cmdData,
	input logic rspValid,
	input logic [tsio_pkg::DATA_W-1:0] rspData,
	// Pins
	input logic [tsio_pkg::NPIN-1:0] linkEn,
	input logic [tsio_pkg::NPIN-1:0] pinIn,
	input logic [tsio_pkg::NPIN-1:0] pinOe
);
	import tsio_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic tk;
	logic [CFG_W-1:0] cfgSeen [NPORT];
	assign tk = cmdValid && cmdReady;
	// Last setting written per port; a config command answers the one it replaces
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NPORT; i++) begin
				cfgSeen[i] <= CFG_RST;
			end
		end else if (tk && cmdOp == OP_CFG && cmdPort < 3'h5) begin
			cfgSeen[cmdPort] <= cmdData[CFG_W-1:0];
		end
	end
	property p_rspNext; tk |=> rspValid; endproperty
	property p_rspCause; rspValid |-> $past(tk); endproperty
	property p_rspHold; !tk |=> $stable(rspData); endproperty
	property p_linkFree; (linkEn & pinOe) == '0; endproperty
	property p_unmapped; tk && cmdPort > 3'h4 |=> rspData == '0; endproperty
	property p_peek;
		tk && cmdOp == OP_PEEK && cmdPort inside {3'h3, 3'h4} |=>
			rspData == ($past(pinIn) & ($past(cmdPort) == 3'h4 ? 32'hFFFFFFFF : 32'h0000FFFF));
	endproperty
	property p_cfgEcho;
		tk && cmdOp == OP_CFG && cmdPort < 3'h5 |=>
			rspData == {27'h0000000, $past(cfgSeen[cmdPort])};
	endproperty
	property p_zeroAns; tk && cmdOp inside {OP_OUT, OP_TIME, OP_COND} |=> rspData == '0; endproperty
	a_rspNext: assert property (p_rspNext) else $error("command not answered");
	a_rspCause: assert property (p_rspCause) else $error("answer without command");
	a_rspHold: assert property (p_rspHold) else $error("answer data moved");
	a_linkFree: assert property (p_linkFree) else $error("link pin driven");
	a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
	a_peek: assert property (p_peek) else $error("peek value wrong");
	a_cfgEcho: assert property (p_cfgEcho) else $error("config echo wrong");
	a_zeroAns: assert property (p_zeroAns) else $error("answer not zero");
	c_in: cover property (tk && cmdOp == OP_IN);
	c_time: cover property (tk && cmdOp == OP_TIME);
	c_link: cover property (linkEn != '0);
endmodule : tsio_port_sva

bind tsio_port_top tsio_port_sva u_sva (.clk_sys, .rstn, .cmdValid, .cmdReady, .cmdPort,
	.cmdOp, .cmdData, .rspValid, .rspData, .linkEn, .pinIn, .pinOe);

//--- tb/tsio_ext_model.sv
`timescale 1ns/1ps
module tsio_ext_model (
	// Device pins
	input logic [tsio_pkg::NPIN-1:0] pinOut,
	input logic [tsio_pkg::NPIN-1:0] pinOe,
	output logic [tsio_pkg::NPIN-1:0] pinIn,
	// Far side drive
	input logic [tsio_pkg::NPIN-1:0] extVal,
	input logic [tsio_pkg::NPIN-1:0] extDrv
);
	import tsio_pkg::*;
	// Undriven pins sit on their pull-down
	assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extVal);
endmodule : tsio_ext_model

//--- tb/timed_serdes_io_port_bench.sv
`timescale 1ns/1ps
module timed_serdes_io_port_bench;
	import tsio_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cmdValid = 1'b0;
	logic [2:0] cmdPort = 3'h0;
	tsio_op_t cmdOp = OP_CFG;
	logic [31:0] cmdData = '0, rsp, w;
	logic [15:0] t;
	logic [4:0] readyIn = 5'h00;
	logic [31:0] linkEn = '0, extVal = 32'h0000BEEF, extDrv = '0;
	logic cmdReady, rspValid;
	logic [31:0] rspData, pinIn, pinOut, pinOe;
	logic [4:0] portEvent, readyOut;
	int fails = 0, testsRun = 0;
	always #20 clk_sys = ~clk_sys;
	tsio_port_top DUT (.clk_sys, .rstn, .cmdValid, .cmdReady, .cmdPort, .cmdOp, .cmdData,
		.rspValid, .rspData, .portEvent, .readyIn, .readyOut, .linkEn, .pinIn, .pinOut, .pinOe);
	tsio_ext_model EXT (.pinOut, .pinOe, .pinIn, .extVal, .extDrv);
	task automatic tally_and_finish;
		$display("compared %0d, bad %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Request held until taken; ends at the falling edge after it
	task automatic cmd(input logic [2:0] p, input tsio_op_t o, input logic [31:0] d);
		int n = 0;
		cmdValid = 1'b1;
		cmdPort = p;
		cmdOp = o;
		cmdData = d;
		// Ready looked at mid-cycle, where it has settled
		#1;
		while (cmdReady !== 1'b1) begin
			if (++n > 300) begin
				fails++;
				tally_and_finish;
			end
			@(negedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk({31'h00000000, rspValid}, 32'h00000001);
		rsp = rspData;
	endtask : cmd
	task automatic idle(input int c);
		cmdValid = 1'b0;
		repeat (c) @(negedge clk_sys);
	endtask : idle
	task automatic waitFor(input bit ev, input int k);
		int n = 0;
		while ((ev ? portEvent[k] : readyOut[k]) !== 1'b1) begin
			if (++n > 300) begin
				fails++;
				tally_and_finish;
			end
			@(negedge clk_sys);
		end
	endtask : waitFor
	task automatic beat(input int p, input logic [31:0] m, exp, oe);
		waitFor(1'b0, p);
		chk(pinOut & pinOe & m, exp);
		chk(pinOe & m, oe);
		@(negedge clk_sys);
	endtask : beat
	initial begin
		repeat (12) @(negedge clk_sys);
		rstn = 1'b1;
		cmd(3'h5, OP_CNT, '0);
		chk(rsp, '0);
		cmd(3'h7, OP_CFG, 32'h0000001F);
		chk(rsp, '0);
		cmd(3'h4, OP_CFG, 32'h00000003);
		chk(rsp, '0);
		cmd(3'h4, OP_CFG, 32'h00000003);
		chk(rsp, 32'h00000003);
		cmd(3'h4, OP_OUT, 32'hAABBCCDD);
		idle(0);
		beat(4, 32'hFFFFFFFF, 32'hAABBCCDD, 32'hFFFFFFFF);
		cmd(3'h2, OP_CFG, 32'h00000003);
		w = 32'h44332211;
		cmd(3'h2, OP_OUT, w);
		idle(0);
		for (int i = 0; i < 4; i++) begin
			beat(2, 32'hFFFFFFFF, {24'hAABBCC, w[8*i+:8]}, 32'hFFFFFFFF);
		end
		$display("output test done");
		cmd(3'h2, OP_CNT, '0);
		w = rsp;
		cmd(3'h2, OP_CNT, '0);
		chk(rsp, {16'h0000, w[15:0] + 16'h0001});
		idle(65545);
		cmd(3'h2, OP_CNT, '0);
		chk(rsp, {16'h0000, w[15:0] + 16'h000B});
		t = rsp[15:0] + 16'h0014;
		cmd(3'h2, OP_TIME, {16'h0000, t});
		cmd(3'h2, OP_OUT, 32'h000000A5);
		idle(0);
		beat(2, 32'h000000FF, 32'h000000A5, 32'h000000FF);
		cmd(3'h2, OP_TS, '0);
		chk(rsp, {16'h0000, t});
		$display("counter test done");
		cmd(3'h1, OP_CFG, 32'h00000007);
		cmd(3'h1, OP_OUT, 32'h0000000A);
		idle(0);
		beat(1, 32'h0000000F, '0, 32'h00000005);
		extDrv = 32'h0000FFFF;
		cmd(3'h1, OP_CFG, '0);
		cmd(3'h2, OP_CFG, '0);
		cmd(3'h3, OP_CFG, 32'h00000001);
		idle(0);
		waitFor(1'b1, 3);
		chk(pinOe & 32'h0000FFFF, '0);
		cmd(3'h3, OP_PEEK, '0);
		chk(rsp, 32'h0000BEEF);
		cmd(3'h3, OP_IN, '0);
		chk(rsp, 32'hBEEFBEEF);
		cmd(3'h3, OP_CFG, 32'h00000011);
		chk(rsp, 32'h00000001);
		cmdOp = OP_IN;
		idle(4);
		chk({31'h00000000, cmdReady}, '0);
		readyIn = 5'h08;
		waitFor(1'b1, 3);
		readyIn = 5'h00;
		cmd(3'h3, OP_IN, '0);
		chk(rsp, 32'hBEEFBEEF);
		cmd(3'h3, OP_COND, 32'h0000BEE0);
		readyIn = 5'h08;
		cmdOp = OP_IN;
		idle(4);
		chk({31'h00000000, cmdReady}, '0);
		extVal = 32'h0000BEE0;
		waitFor(1'b1, 3);
		readyIn = 5'h00;
		cmd(3'h3, OP_IN, '0);
		chk(rsp, 32'hBEE0BEE0);
		cmd(3'h0, OP_CFG, 32'h00000001);
		cmd(3'h1, OP_CFG, 32'h00000009);
		cmd(3'h1, OP_CNT, '0);
		w = rsp;
		idle(0);
		repeat (3) begin
			extVal[0] = 1'b1;
			@(negedge clk_sys);
			extVal[0] = 1'b0;
			@(negedge clk_sys);
		end
		cmd(3'h1, OP_CNT, '0);
		chk(rsp, {16'h0000, w[15:0] + 16'h0003});
		$display("strobe, condition and clock test done");
		idle(1);
		linkEn = 32'hFF000000;
		@(negedge clk_sys);
		chk(pinOe & 32'hFF000000, '0);
		$display("input and link test done");
		rstn = 1'b0;
		@(negedge clk_sys);
		chk(pinOe, '0);
		rstn = 1'b1;
		cmd(3'h6, OP_CNT, '0);
		chk(rsp, '0);
		cmd(3'h4, OP_CFG, '0);
		chk(rsp, '0);
		idle(1);
		$display("reset test done");
		tally_and_finish;
	end
endmodule : timed_serdes_io_port_bench
